// ==== design/dscmm_top.sv ====
// Function
// - Program addresses are 21-bit and data addresses 24-bit word addresses.
// - Fetch uses program address bus, returns word on fetch bus.
// - Program space readable over primary data buses, writable there only in RAM.
// - Data-bus access to program space takes extra wait cycles.
// - Large variant: flash 0x0000-0x1fff, vectors 0x0000-0x0065.
// - Small variant: flash 0x0800-0x1fff, below reserved, vectors 0x0800.
// - Program 0x8000-0x83ff and data 0x0000-0x03ff share one RAM.
// - RAM serves primary buses and a parallel secondary 16-bit read.
// - Primary buses are 32-bit with byte, word and long transfers.
// - Short direct mode reaches only the lowest 64 data words.
// - Peripherals at 0xf000-0xffff, debug at 0xffff00-0xffffff.
// - Peripheral selects from fixed bases, timer 0xf000 to flash 0xf400.
// - Vector address is 21 bits, upper 14 from vector base.
// - Low seven vector bits encode highest-priority pending interrupt.
// - Large variant vector base resets to 0x0000.
// - Small variant vector base resets to 0x0010.
// - Chip reset uses entry 0, watchdog reset entry 1.
// - Last user vector is fast unless it holds a subroutine call.
// - Flash written only through flash interface with word writes.
`timescale 1ns/100ps
`default_nettype none
module dscmm_top #(
   parameter bit SMALL_FLASH = 1'b0,
   parameter int RAM_DEPTH = 1024
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Program fetch
   input wire logic fetch_req,
   input wire logic [20:0] program_addr_bus,
   output logic [15:0] program_fetch_bus,
   output logic fetch_ack,
   // Primary data bus
   input wire dscmm_pkg::dscmm_req_t pri_req,
   input wire logic [23:0] primary_data_addr_bus,
   input wire logic [31:0] primary_write_bus,
   output logic [31:0] primary_read_bus,
   output logic pri_ack,
   output logic pri_size_err,
   // Secondary data bus
   input wire logic sec_req,
   input wire logic [23:0] secondary_data_addr_bus,
   output logic [15:0] secondary_read_bus,
   output logic sec_ack,
   // Flash array port
   output logic flash_rd,
   output logic flash_wr,
   output logic [12:0] flash_addr,
   output logic [15:0] flash_wdata,
   input wire logic [15:0] flash_rdata,
   // Peripheral and debug windows
   output dscmm_pkg::dscmm_sel_t sel,
   output logic [26:0] periph_sel,
   output logic [7:0] periph_addr,
   output logic pd_wr,
   output logic [15:0] pd_wdata,
   input wire logic [15:0] periph_rdata,
   input wire logic [15:0] debug_rdata,
   // Vectors
   input wire logic vbr_we,
   input wire logic [13:0] vbr_wdata,
   input wire logic chip_reset_req,
   input wire logic watchdog_reset,
   input wire logic irq_valid,
   input wire logic [6:0] irq_num,
   input wire logic [15:0] last_user_vector,
   output logic [13:0] vector_base_reg,
   output logic [20:0] vector_addr,
   output logic vec_valid,
   output logic last_user_fast
);
   localparam int AW = $clog2(RAM_DEPTH);
   localparam logic [20:0] FLO = SMALL_FLASH ? dscmm_pkg::P_FLASH_LO_SMALL
                                             : dscmm_pkg::P_FLASH_LO_BIG;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} dscmm_state_t;
   typedef struct packed {
      dscmm_state_t state;
      logic [1:0] wait_cnt;
      logic f_ack;
      logic f_flash;
      logic f_ram;
      logic p_ack;
      logic p_serr;
      logic [3:0] p_src;
      logic [31:0] p_rdata;
      logic s_ack;
      logic s_ram;
      logic s_short_hit;
      logic fl_rd;
      logic fl_wr;
      logic [12:0] fl_addr;
      logic [15:0] fl_wdata;
      dscmm_pkg::dscmm_sel_t sel;
      logic [26:0] psel;
      logic [7:0] paddr;
      logic pdwr;
      logic [15:0] pdwdata;
      logic fast;
   } dscmm_st_t;
   dscmm_st_t st;
   dscmm_st_t next_st;
   logic [23:0] xa;
   logic xa_ram;
   logic xa_periph;
   logic xa_debug;
   logic pa_ram;
   logic pa_flash;
   logic fa_ram;
   logic fa_flash;
   logic sa_ram;
   logic ram_a_en;
   logic ram_a_wr;
   logic [AW-1:0] ram_a_addr;
   logic [1:0] ram_be;
   logic [31:0] ram_a_rdata;
   logic [15:0] ram_b_rdata;
   logic [26:0] slot;
   logic subr;
   // Short direct form forces the top address bits to zero
   assign xa = pri_req.short_mode ? {18'h0, primary_data_addr_bus[5:0]}
                                  : primary_data_addr_bus;
   assign xa_ram = xa <= dscmm_pkg::X_RAM_HI;
   assign xa_periph = xa >= dscmm_pkg::X_PERIPH_LO
                      && xa <= dscmm_pkg::X_PERIPH_HI;
   assign xa_debug = xa >= dscmm_pkg::X_DEBUG_LO;
   assign pa_ram = xa[20:0] >= dscmm_pkg::P_RAM_LO
                   && xa[20:0] <= dscmm_pkg::P_RAM_HI && xa[23:21] == 3'h0;
   assign pa_flash = xa[20:0] >= FLO && xa[20:0] <= dscmm_pkg::P_FLASH_HI
                     && xa[23:21] == 3'h0;
   assign fa_ram = program_addr_bus >= dscmm_pkg::P_RAM_LO
                   && program_addr_bus <= dscmm_pkg::P_RAM_HI;
   assign fa_flash = program_addr_bus >= FLO
                     && program_addr_bus <= dscmm_pkg::P_FLASH_HI;
   assign sa_ram = secondary_data_addr_bus <= dscmm_pkg::X_RAM_HI;
   // One select per 32-word peripheral window, flash interface at its base
   for (genvar g = 0; g < dscmm_pkg::PERIPH_SLOTS; g++) begin : g_slot
      if (g == dscmm_pkg::FLASH_IF_SEL) begin : g_fm
         assign slot[g] = xa_periph
            && xa[11:5] == dscmm_pkg::X_FLASH_IF_BASE[11:5];
      end else begin : g_pr
         assign slot[g] = xa_periph && xa[11:5] == 7'(g);
      end
   end
   // Data access to program RAM has priority over fetch on RAM port A
   always_comb begin
      ram_a_en = 1'b0;
      ram_a_wr = 1'b0;
      ram_a_addr = program_addr_bus[AW-1:0];
      ram_be = 2'b00;
      if ((pri_req.rd || pri_req.wr) && st.state == ST_IDLE
          && (pri_req.pspace ? pa_ram : xa_ram)) begin
         ram_a_en = 1'b1;
         ram_a_wr = pri_req.wr;
         ram_a_addr = xa[AW-1:0];
         ram_be = (pri_req.size == dscmm_pkg::DSCMM_LONG) ? 2'b11
                : (pri_req.size == dscmm_pkg::DSCMM_WORD) ? 2'b01 : 2'b00;
      end else if (fetch_req && fa_ram) begin
         ram_a_en = 1'b1;
      end
   end
   assign subr = (last_user_vector & dscmm_pkg::SUBR_JUMP_MASK)
                    == dscmm_pkg::SUBR_JUMP_CODE
                 || (last_user_vector & dscmm_pkg::SUBR_JUMP_MASK)
                    == dscmm_pkg::SUBR_BRANCH_CODE;
   always_comb begin
      next_st = st;
      next_st.f_ack = 1'b0;
      next_st.p_ack = 1'b0;
      next_st.s_ack = 1'b0;
      next_st.fl_rd = 1'b0;
      next_st.fl_wr = 1'b0;
      next_st.pdwr = 1'b0;
      next_st.p_serr = 1'b0;
      next_st.sel = '0;
      next_st.psel = '0;
      next_st.fast = !subr;
      // Fetch stalls while the primary bus holds RAM port A
      if (fetch_req && !(ram_a_en && !(fetch_req && fa_ram && ram_a_addr
                          == program_addr_bus[AW-1:0] && !ram_a_wr
                          && !(pri_req.rd || pri_req.wr)))) begin
         next_st.f_ack = 1'b1;
         next_st.f_ram = fa_ram;
         next_st.f_flash = fa_flash;
         if (fa_flash && !(st.state == ST_IDLE && pri_req.pspace
                           && (pri_req.rd || pri_req.wr) && pa_flash)) begin
            next_st.fl_rd = 1'b1;
            next_st.fl_addr = program_addr_bus[12:0];
         end
      end
      next_st.s_ack = sec_req;
      next_st.s_ram = sa_ram;
      case (st.state)
         ST_IDLE: begin
            if (pri_req.rd || pri_req.wr) begin
               next_st.p_src = 4'h0;
               next_st.pdwr = pri_req.wr;
               next_st.pdwdata = primary_write_bus[15:0];
               next_st.paddr = xa[7:0];
               if (pri_req.pspace) begin
                  next_st.state = ST_WAIT;
                  next_st.wait_cnt = 2'(dscmm_pkg::PSPACE_WAIT);
                  if (pa_flash) begin
                     next_st.p_src = 4'h2;
                     next_st.fl_rd = pri_req.rd;
                     next_st.fl_addr = xa[12:0];
                  end else if (pa_ram) begin
                     next_st.p_src = 4'h1;
                  end
               end else begin
                  next_st.p_ack = 1'b1;
                  if (xa_ram) begin
                     next_st.p_src = 4'h1;
                  end else if (xa_periph) begin
                     next_st.p_src = 4'h4;
                     next_st.sel.periph = 1'b1;
                     next_st.psel = slot;
                     next_st.p_serr = pri_req.size != dscmm_pkg::DSCMM_WORD;
                  end else if (xa_debug) begin
                     next_st.p_src = 4'h8;
                     next_st.sel.debug = 1'b1;
                  end else begin
                     next_st.pdwr = 1'b0;
                  end
                  next_st.sel.ram = xa_ram;
               end
               if (!xa_periph && !xa_debug) begin
                  next_st.pdwr = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            next_st.sel.flash = st.p_src == 4'h2;
            next_st.wait_cnt = st.wait_cnt - 2'h1;
            if (st.wait_cnt == 2'h1) begin
               next_st.state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_st.p_ack = 1'b1;
            next_st.state = ST_IDLE;
         end
         default: next_st.state = ST_IDLE;
      endcase
      if (st.state == ST_IDLE && pri_req.wr && xa_periph
          && slot[dscmm_pkg::FLASH_IF_SEL]
          && pri_req.size == dscmm_pkg::DSCMM_WORD) begin
         next_st.fl_wr = 1'b1;
         next_st.fl_addr = primary_write_bus[28:16];
         next_st.fl_wdata = primary_write_bus[15:0];
      end
      if (st.state == ST_WAIT && st.p_src == 4'h2
          && st.wait_cnt == 2'(dscmm_pkg::PSPACE_WAIT)) begin
         next_st.p_rdata = {16'h0, flash_rdata};
      end else if (st.state == ST_IDLE) begin
         next_st.p_rdata = 32'h0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.state <= ST_IDLE;
      end else begin
         st <= next_st;
      end
   end
   dscmm_ram #(.DEPTH(RAM_DEPTH), .AW(AW)) u_ram (
      .clk(clk),
      .a_en(ram_a_en),
      .a_wr(ram_a_wr),
      .a_addr(ram_a_addr),
      .a_be(ram_be),
      .a_wdata(primary_write_bus),
      .a_rdata(ram_a_rdata),
      .b_en(sec_req && sa_ram),
      .b_addr(secondary_data_addr_bus[AW-1:0]),
      .b_rdata(ram_b_rdata)
   );
   dscmm_vec #(.SMALL_FLASH(SMALL_FLASH)) u_vec (
      .clk(clk),
      .rst(rst),
      .vbr_we(vbr_we),
      .vbr_wdata(vbr_wdata),
      .chip_reset_req(chip_reset_req),
      .watchdog_reset(watchdog_reset),
      .irq_valid(irq_valid),
      .irq_num(irq_num),
      .vector_base_reg(vector_base_reg),
      .vector_addr(vector_addr),
      .vec_valid(vec_valid)
   );
   always_ff @(posedge clk) begin
      if (rst) begin
         program_fetch_bus <= 16'h0;
         primary_read_bus <= 32'h0;
         secondary_read_bus <= 16'h0;
      end else begin
         program_fetch_bus <= 16'h0;
         if (st.f_ack && st.f_ram) begin
            program_fetch_bus <= ram_a_rdata[15:0];
         end else if (st.f_ack && st.f_flash) begin
            program_fetch_bus <= flash_rdata;
         end
         secondary_read_bus <= st.s_ram ? ram_b_rdata : 16'h0;
         primary_read_bus <= st.p_src == 4'h4 ? {16'h0, periph_rdata}
                           : st.p_src == 4'h8 ? {16'h0, debug_rdata}
                           : st.p_src == 4'h1 ? ram_a_rdata
                           : st.p_rdata;
      end
   end
   assign fetch_ack = st.f_ack;
   assign pri_ack = st.p_ack;
   assign pri_size_err = st.p_serr;
   assign sec_ack = st.s_ack;
   assign flash_rd = st.fl_rd;
   assign flash_wr = st.fl_wr;
   assign flash_addr = st.fl_addr;
   assign flash_wdata = st.fl_wdata;
   assign sel = st.sel;
   assign periph_sel = st.psel;
   assign periph_addr = st.paddr;
   assign pd_wr = st.pdwr;
   assign pd_wdata = st.pdwdata;
   assign last_user_fast = st.fast;
endmodule : dscmm_top
`default_nettype wire

// ==== design/dscmm_pkg.sv ====
package dscmm_pkg;
   // Word address widths
   localparam int PADDR_W = 21;
   localparam int XADDR_W = 24;
   // Program space map
   localparam logic [20:0] P_FLASH_LO_BIG = 21'h000000;
   localparam logic [20:0] P_FLASH_LO_SMALL = 21'h000800;
   localparam logic [20:0] P_FLASH_HI = 21'h001fff;
   localparam logic [20:0] P_RAM_LO = 21'h008000;
   localparam logic [20:0] P_RAM_HI = 21'h0083ff;
   localparam logic [20:0] P_VEC_END_BIG = 21'h000065;
   localparam logic [20:0] P_VEC_END_SMALL = 21'h000865;
   // Data space map
   localparam logic [23:0] X_RAM_LO = 24'h000000;
   localparam logic [23:0] X_RAM_HI = 24'h0003ff;
   localparam logic [23:0] X_PERIPH_LO = 24'h00f000;
   localparam logic [23:0] X_PERIPH_HI = 24'h00ffff;
   localparam logic [23:0] X_DEBUG_LO = 24'hffff00;
   localparam logic [23:0] X_DEBUG_HI = 24'hffffff;
   localparam logic [23:0] X_SHORT_HI = 24'h00003f;
   // Peripheral windows: 32 words each from 0xf000, flash interface at 0xf400
   localparam int PERIPH_SLOTS = 27;
   localparam logic [23:0] X_FLASH_IF_BASE = 24'h00f400;
   localparam int FLASH_IF_SEL = 26;
   localparam int PERIPH_SHIFT = 5;
   // Vector base reset values per variant
   localparam logic [13:0] VBR_RST_BIG = 14'h0000;
   localparam logic [13:0] VBR_RST_SMALL = 14'h0010;
   localparam logic [6:0] VEC_CHIP_RESET = 7'h00;
   localparam logic [6:0] VEC_WATCHDOG = 7'h01;
   localparam logic [6:0] VEC_LAST_USER = 7'h32;
   localparam logic [15:0] SUBR_JUMP_MASK = 16'hff00;
   localparam logic [15:0] SUBR_JUMP_CODE = 16'he200;
   localparam logic [15:0] SUBR_BRANCH_CODE = 16'he300;
   // Wait cycles for data-bus access to program space
   localparam int PSPACE_WAIT = 2;
   // Transfer sizes on the primary buses
   typedef enum logic [1:0] {DSCMM_BYTE, DSCMM_WORD, DSCMM_LONG}
      dscmm_size_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic pspace;
      logic short_mode;
      dscmm_size_t size;
      logic [23:0] addr;
      logic [31:0] wdata;
   } dscmm_req_t;
   typedef struct packed {
      logic ram;
      logic flash;
      logic periph;
      logic debug;
   } dscmm_sel_t;
endpackage : dscmm_pkg

// ==== design/dscmm_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
module dscmm_ram #(
   parameter int DEPTH = 1024,
   parameter int AW = 10
) (
   // Clock
   input wire logic clk,
   // Port A read/write
   input wire logic a_en,
   input wire logic a_wr,
   input wire logic [AW-1:0] a_addr,
   input wire logic [1:0] a_be,
   input wire logic [31:0] a_wdata,
   output logic [31:0] a_rdata,
   // Port B read
   input wire logic b_en,
   input wire logic [AW-1:0] b_addr,
   output logic [15:0] b_rdata
);
   logic [15:0] mem [DEPTH];
   logic [AW-1:0] a_next;
   assign a_next = a_addr + AW'(1);
   always_ff @(posedge clk) begin
      if (a_en && a_wr && a_be[0]) begin
         mem[a_addr] <= a_wdata[15:0];
      end
      if (a_en && a_wr && a_be[1]) begin
         mem[a_next] <= a_wdata[31:16];
      end
      if (a_en && a_wr && a_be == 2'b00) begin
         mem[a_addr][7:0] <= a_wdata[7:0];
      end
      if (a_en) begin
         a_rdata <= {mem[a_next], mem[a_addr]};
      end
      if (b_en) begin
         b_rdata <= mem[b_addr];
      end
   end
endmodule : dscmm_ram
`default_nettype wire

// ==== design/dscmm_vec.sv ====
`timescale 1ns/100ps
`default_nettype none
module dscmm_vec #(
   parameter bit SMALL_FLASH = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Base register write
   input wire logic vbr_we,
   input wire logic [13:0] vbr_wdata,
   // Interrupt request
   input wire logic chip_reset_req,
   input wire logic watchdog_reset,
   input wire logic irq_valid,
   input wire logic [6:0] irq_num,
   // Vector result
   output logic [13:0] vector_base_reg,
   output logic [20:0] vector_addr,
   output logic vec_valid
);
   typedef struct packed {
      logic [13:0] vbr;
      logic [20:0] va;
      logic vld;
   } dscmm_vst_t;
   dscmm_vst_t st;
   dscmm_vst_t next_st;
   logic [6:0] num;
   always_comb begin
      next_st = st;
      next_st.vld = 1'b0;
      num = irq_num;
      if (chip_reset_req) begin
         num = dscmm_pkg::VEC_CHIP_RESET;
      end else if (watchdog_reset) begin
         num = dscmm_pkg::VEC_WATCHDOG;
      end
      if (vbr_we) begin
         next_st.vbr = vbr_wdata;
      end
      if (chip_reset_req || watchdog_reset || irq_valid) begin
         next_st.va = {st.vbr, num};
         next_st.vld = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st.vbr <= SMALL_FLASH ? dscmm_pkg::VBR_RST_SMALL
                               : dscmm_pkg::VBR_RST_BIG;
         st.va <= '0;
         st.vld <= 1'b0;
      end else begin
         st <= next_st;
      end
   end
   assign vector_base_reg = st.vbr;
   assign vector_addr = st.va;
   assign vec_valid = st.vld;
endmodule : dscmm_vec
`default_nettype wire

// ==== testbench/dscmm_top_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module dscmm_top_chk #(
   parameter bit SMALL_FLASH = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Buses
   input wire logic fetch_req,
   input wire logic fetch_ack,
   input wire dscmm_pkg::dscmm_req_t pri_req,
   input wire logic pri_ack,
   input wire logic pri_size_err,
   input wire logic sec_req,
   input wire logic sec_ack,
   input wire dscmm_pkg::dscmm_sel_t sel,
   input wire logic [26:0] periph_sel,
   // Vectors
   input wire logic chip_reset_req,
   input wire logic watchdog_reset,
   input wire logic irq_valid,
   input wire logic [6:0] irq_num,
   input wire logic [13:0] vector_base_reg,
   input wire logic [20:0] vector_addr,
   input wire logic vec_valid
);
   localparam logic [13:0] VBR_EXP = SMALL_FLASH ?
      dscmm_pkg::VBR_RST_SMALL : dscmm_pkg::VBR_RST_BIG;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_vbr_rst;
      !rst && $past(rst) |-> vector_base_reg == VBR_EXP;
   endproperty
   a_vbr_rst: assert property (p_vbr_rst)
      else $error("vector base reset value wrong");
   property p_vec_base;
      vec_valid |-> vector_addr[20:7] == vector_base_reg;
   endproperty
   a_vec_base: assert property (p_vec_base)
      else $error("vector upper bits differ from base");
   property p_vec_chip;
      chip_reset_req |=> vec_valid && vector_addr[6:0] == 7'h00;
   endproperty
   a_vec_chip: assert property (p_vec_chip)
      else $error("chip reset vector wrong");
   property p_vec_wd;
      watchdog_reset && !chip_reset_req |=> vec_valid &&
         vector_addr[6:0] == 7'h01;
   endproperty
   a_vec_wd: assert property (p_vec_wd)
      else $error("watchdog vector wrong");
   property p_vec_irq;
      irq_valid && !watchdog_reset && !chip_reset_req |=> vec_valid &&
         vector_addr[6:0] == $past(irq_num);
   endproperty
   a_vec_irq: assert property (p_vec_irq)
      else $error("interrupt vector number wrong");
   property p_pspace_wait;
      pri_ack && $past(pri_req.pspace) |-> $past(pri_req.pspace, 4);
   endproperty
   a_pspace_wait: assert property (p_pspace_wait)
      else $error("program space access answered too early");
   property p_sel_one;
      $onehot0(sel);
   endproperty
   a_sel_one: assert property (p_sel_one)
      else $error("more than one target selected");
   property p_periph;
      periph_sel != 27'h0 |-> sel.periph && $onehot(periph_sel);
   endproperty
   a_periph: assert property (p_periph)
      else $error("peripheral select not one-hot");
   property p_size;
      pri_size_err |-> $past(pri_req.size) != dscmm_pkg::DSCMM_WORD;
   endproperty
   a_size: assert property (p_size)
      else $error("size error on word access");
   property p_fetch;
      fetch_ack |-> $past(fetch_req);
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("fetch answered without request");
   property p_sec;
      sec_ack |-> $past(sec_req);
   endproperty
   a_sec: assert property (p_sec)
      else $error("secondary answered without request");
endmodule : dscmm_top_chk
bind dscmm_top dscmm_top_chk #(.SMALL_FLASH(SMALL_FLASH)) i_chk (.*);
`default_nettype wire

// ==== testbench/dscmm_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dscmm_far_model (
   // Clock
   input wire logic clk,
   // Flash array
   input wire logic flash_rd,
   input wire logic [12:0] flash_addr,
   output logic [15:0] flash_rdata,
   // Peripheral and debug windows
   input wire dscmm_pkg::dscmm_sel_t sel,
   input wire logic [7:0] periph_addr,
   output logic [15:0] periph_rdata,
   output logic [15:0] debug_rdata
);
   logic fl_hold = 1'b0;
   logic pd_hold = 1'b0;
   logic [15:0] fl_word;
   logic [15:0] pd_word;
   always @(posedge clk) begin
      fl_hold <= flash_rd;
      pd_hold <= sel.periph | sel.debug;
   end
   // Released flash and peripheral lines show the inverted pattern, released debug lines the plain one
   assign fl_word = {3'h5, flash_addr};
   assign flash_rdata = (flash_rd | fl_hold) ? fl_word : ~fl_word;
   assign pd_word = {8'ha5, periph_addr};
   assign periph_rdata = (sel.periph | pd_hold) ? pd_word : ~pd_word;
   assign debug_rdata = (sel.debug | pd_hold) ? ~pd_word : pd_word;
endmodule : dscmm_far_model
`default_nettype wire

// ==== testbench/dscmm_memory_map_vector_decode_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module dsc_memory_map_vector_decode_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fetch_req = 1'b0;
   logic [20:0] program_addr_bus = 21'h0;
   logic [15:0] program_fetch_bus;
   logic fetch_ack;
   dscmm_pkg::dscmm_req_t pri_req = '0;
   logic [23:0] primary_data_addr_bus = 24'h0;
   logic [31:0] primary_write_bus = 32'h0;
   logic [31:0] primary_read_bus;
   logic pri_ack, pri_size_err, sec_ack, flash_rd, flash_wr, pd_wr;
   logic sec_req = 1'b0;
   logic [23:0] secondary_data_addr_bus = 24'h0;
   logic [15:0] secondary_read_bus, flash_wdata, flash_rdata, pd_wdata;
   logic [12:0] flash_addr;
   dscmm_pkg::dscmm_sel_t sel, s_sel;
   logic [26:0] periph_sel, s_psel;
   logic [7:0] periph_addr;
   logic [15:0] periph_rdata, debug_rdata;
   logic vbr_we = 1'b0;
   logic [13:0] vbr_wdata = 14'h0;
   logic chip_reset_req = 1'b0;
   logic watchdog_reset = 1'b0;
   logic irq_valid = 1'b0;
   logic [6:0] irq_num = 7'h0;
   logic [15:0] last_user_vector = 16'h0;
   logic [13:0] vector_base_reg;
   logic [20:0] vector_addr;
   logic vec_valid, last_user_fast, s_err;
   logic fw_seen = 1'b0;
   logic [12:0] fw_addr;
   logic [15:0] fw_data;
   logic [31:0] r;
   logic [15:0] f;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int l1, l2;
   always #2.5 clk = ~clk;
   dscmm_top #(.SMALL_FLASH(1'b0), .RAM_DEPTH(1024)) i_dut (.*);
   dscmm_far_model i_far (.*);
   always @(posedge clk) begin
      cyc++;
      if (flash_wr === 1'b1) begin
         fw_seen <= pd_wr && pd_wdata === flash_wdata;
         fw_addr <= flash_addr;
         fw_data <= flash_wdata;
      end
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic pri(input logic rd, input logic wr, input logic ps,
         input logic sh, input dscmm_pkg::dscmm_size_t sz,
         input logic [23:0] a, input logic [31:0] wd, output int lat);
      @(negedge clk);
      pri_req = {rd, wr, ps, sh, sz, a, wd};
      primary_data_addr_bus = a;
      primary_write_bus = wd;
      lat = 0;
      do begin
         @(posedge clk);
         lat++;
         @(negedge clk);
      end while (pri_ack !== 1'b1 && lat < 12);
      s_sel = sel;
      s_psel = periph_sel;
      s_err = pri_size_err;
      pri_req = '0;
      @(negedge clk);
      r = primary_read_bus;
   endtask : pri
   task automatic rd16(input logic s, input logic [23:0] a);
      int n;
      n = 0;
      @(negedge clk);
      {sec_req, fetch_req} = {s, !s};
      program_addr_bus = a[20:0];
      secondary_data_addr_bus = a;
      do begin
         @(posedge clk);
         n++;
         @(negedge clk);
      end while ((s ? sec_ack : fetch_ack) !== 1'b1 && n < 12);
      {sec_req, fetch_req} = 2'h0;
      @(negedge clk);
      f = s ? secondary_read_bus : program_fetch_bus;
   endtask : rd16
   task automatic vec(input logic c, input logic w, input logic i,
         input logic [6:0] num, input logic [20:0] exp);
      @(negedge clk);
      {chip_reset_req, watchdog_reset, irq_valid} = {c, w, i};
      irq_num = num;
      @(negedge clk);
      {chip_reset_req, watchdog_reset, irq_valid} = 3'h0;
      `CHK({vec_valid, vector_addr}, {1'b1, exp})
   endtask : vec
   task automatic t_ram_share();
      pri(0, 1, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h000005, 32'h1234, l1);
      rd16(0, 24'h008005);
      `CHK(f, 16'h1234)
      rd16(1, 24'h000005);
      `CHK(f, 16'h1234)
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h000005, 32'h0, l1);
      `CHK(r[15:0], 16'h1234)
      pri(1, 0, 1, 0, dscmm_pkg::DSCMM_WORD, 24'h008005, 32'h0, l2);
      `CHK(r[15:0], 16'h1234)
      `CHK(l2, l1 + dscmm_pkg::PSPACE_WAIT + 1)
      pri(0, 1, 1, 0, dscmm_pkg::DSCMM_WORD, 24'h008006, 32'h4321, l2);
      rd16(1, 24'h000006);
      `CHK(f, 16'h4321)
   endtask : t_ram_share
   task automatic t_sizes();
      pri(0, 1, 0, 0, dscmm_pkg::DSCMM_LONG, 24'h10, 32'hbeef5a5a, l2);
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h11, 32'h0, l2);
      `CHK(r[15:0], 16'hbeef)
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_LONG, 24'h10, 32'h0, l2);
      `CHK(r, 32'hbeef5a5a)
      pri(0, 1, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h20, 32'h1111, l2);
      pri(0, 1, 0, 0, dscmm_pkg::DSCMM_BYTE, 24'h20, 32'hc3, l2);
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h20, 32'h0, l2);
      `CHK(r[15:0], 16'h11c3)
      pri(1, 0, 0, 1, dscmm_pkg::DSCMM_WORD, 24'h000051, 32'h0, l2);
      `CHK(r[15:0], 16'hbeef)
   endtask : t_sizes
   task automatic t_periph();
      for (int i = 0; i < 27; i++) begin
         pri(1, 0, 0, 0, dscmm_pkg::DSCMM_WORD,
             i == 26 ? 24'h00f403 : 24'h00f003 + 24'(i * 32), 32'h0, l2);
         `CHK(s_psel, 27'h1 << i)
         `CHK({s_sel.periph, s_err}, 2'h2)
      end
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_WORD, 24'hffff10, 32'h0, l2);
      `CHK(s_sel.debug, 1'b1)
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_BYTE, 24'h00f000, 32'h0, l2);
      `CHK(s_err, 1'b1)
   endtask : t_periph
   task automatic t_reserved();
      pri(0, 1, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h000500, 32'h77, l2);
      pri(1, 0, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h000500, 32'h0, l2);
      `CHK({s_sel, r}, 36'h0)
      `CHK(l2, l1)
      rd16(0, 24'h004000);
      `CHK(f, 16'h0)
      rd16(0, 24'h000123);
      `CHK(f, 16'ha123)
      pri(1, 0, 1, 0, dscmm_pkg::DSCMM_WORD, 24'h000123, 32'h0, l2);
      `CHK(r[15:0], 16'ha123)
   endtask : t_reserved
   task automatic t_flash_write();
      fw_seen = 1'b0;
      pri(0, 1, 1, 0, dscmm_pkg::DSCMM_WORD, 24'h000100, 32'h9999, l2);
      `CHK(fw_seen, 1'b0)
      pri(0, 1, 0, 0, dscmm_pkg::DSCMM_WORD, 24'h00f400, 32'h01235555, l2);
      repeat (4) @(negedge clk);
      `CHK({fw_seen, fw_addr, fw_data}, {1'b1, 13'h0123, 16'h5555})
   endtask : t_flash_write
   task automatic t_vectors();
      logic [15:0] op [3];
      logic exp_fast [3];
      op = '{16'he2a0, 16'h1234, 16'he300};
      exp_fast = '{1'b0, 1'b1, 1'b0};
      vec(1, 1, 1, 7'h05, 21'h000000);
      vec(0, 1, 1, 7'h05, 21'h000001);
      @(negedge clk);
      vbr_we = 1'b1;
      vbr_wdata = 14'h0010;
      @(negedge clk);
      vbr_we = 1'b0;
      vec(0, 0, 1, 7'h32, {14'h0010, 7'h32});
      for (int i = 0; i < 3; i++) begin
         last_user_vector = op[i];
         repeat (2) @(negedge clk);
         `CHK(last_user_fast, exp_fast[i])
      end
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK(vector_base_reg, 14'h0000)
   endtask : t_vectors
   task automatic print_verdict();
      $display("Checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      `CHK(vector_base_reg, 14'h0000)
      t_ram_share();
      t_sizes();
      t_periph();
      t_reserved();
      t_flash_write();
      t_vectors();
      print_verdict();
   end
endmodule : dsc_memory_map_vector_decode_bench
`default_nettype wire
